// *** pkg/exc_seq_pkg.sv ***
package exc_seq_pkg;
    // ---------------------------------------------------------------
    // Widths and table geometry
    // ---------------------------------------------------------------
    localparam int             ADDR_W        = 32;
    localparam int             VEC_W         = 8;
    localparam int             BASE_LSB      = 20;              // 1 Mbyte table alignment
    localparam int             BASE_W        = ADDR_W - BASE_LSB;
    localparam int             VEC_SHIFT     = 2;               // Four bytes per vector
    localparam logic [31:0]    FRAME_BYTES   = 32'h0000_0008;
    localparam logic [31:0]    WORD_BYTES    = 32'h0000_0004;
    localparam logic [31:0]    ALIGN_MASK    = 32'hFFFF_FFFC;
    localparam logic [1:0]     FMT_HI        = 2'h1;            // Format 01xx
    localparam logic [3:0]     FLT_NONE      = 4'h0;

    // ---------------------------------------------------------------
    // Status word fields
    // ---------------------------------------------------------------
    localparam int             PSW_T         = 15;
    localparam int             PSW_S         = 13;
    localparam int             PSW_M         = 12;
    localparam int             PSW_IPL_HI    = 10;
    localparam int             PSW_IPL_LO    = 8;

    // ---------------------------------------------------------------
    // Vector numbers
    // ---------------------------------------------------------------
    localparam logic [7:0]     VEC_ACCESS    = 8'h02;
    localparam logic [7:0]     VEC_ADDRESS   = 8'h03;
    localparam logic [7:0]     VEC_ILLEGAL   = 8'h04;
    localparam logic [7:0]     VEC_DIVZERO   = 8'h05;
    localparam logic [7:0]     VEC_PRIV      = 8'h08;
    localparam logic [7:0]     VEC_TRACE     = 8'h09;
    localparam logic [7:0]     VEC_LINEA     = 8'h0A;
    localparam logic [7:0]     VEC_LINEF     = 8'h0B;
    localparam logic [7:0]     VEC_DEBUG     = 8'h0C;
    localparam logic [7:0]     VEC_FORMAT    = 8'h0E;
    localparam logic [7:0]     VEC_SPURIOUS  = 8'h18;
    localparam logic [7:0]     VEC_TRAP0     = 8'h20;
    localparam logic [7:0]     VEC_PERIPH0   = 8'h40;           // First peripheral vector

    // Vector fetch cycle address: level in bits 4:2 of this window
    localparam logic [31:0]    ACK_BASE      = 32'hFFFF_FFE0;
    localparam int             ACK_LVL_LSB   = 2;

    // Fault status codes
    localparam logic [3:0]     FLT_IFETCH    = 4'h4;
    localparam logic [3:0]     FLT_OPWRITE   = 4'h8;
    localparam logic [3:0]     FLT_WPROT     = 4'h9;
    localparam logic [3:0]     FLT_OPREAD    = 4'hC;

    // Exception causes presented by the core
    typedef enum logic [3:0] {
        CAUSE_ACCESS   = 4'b0000,
        CAUSE_ADDRESS  = 4'b0001,
        CAUSE_ILLEGAL  = 4'b0010,
        CAUSE_DIVZERO  = 4'b0011,
        CAUSE_PRIV     = 4'b0100,
        CAUSE_TRACE    = 4'b0101,
        CAUSE_LINEA    = 4'b0110,
        CAUSE_LINEF    = 4'b0111,
        CAUSE_DEBUG    = 4'b1000,
        CAUSE_FORMAT   = 4'b1001,
        CAUSE_TRAP     = 4'b1010,
        CAUSE_IRQ      = 4'b1011,
        CAUSE_RESET    = 4'b1100
    } cause_t;

    // Fault kinds for access errors
    typedef enum logic [1:0] {
        FAULT_IFETCH   = 2'b00,
        FAULT_OPWRITE  = 2'b01,
        FAULT_WPROT    = 2'b10,
        FAULT_OPREAD   = 2'b11
    } fault_t;

    // Core bus read/write command
    typedef enum logic [1:0] {
        BUS_IDLE       = 2'b00,
        BUS_READ       = 2'b01,
        BUS_WRITE      = 2'b10
    } buscmd_t;
endpackage

// *** pkg/vec_info_if.sv ***
`timescale 1ns/10ps
// Carries cause decode between the sequencer and its vector decoder
interface vec_info_if;
    import exc_seq_pkg::*;
    cause_t     cause;
    logic [3:0] trapNum;
    fault_t     faultKind;
    logic [7:0] vector;
    logic       stackNext;
    logic [3:0] faultCode;
    logic       usesAck;

    modport seq (output cause, output trapNum, output faultKind,
                 input vector, input stackNext, input faultCode, input usesAck);
    modport dec (input cause, input trapNum, input faultKind,
                 output vector, output stackNext, output faultCode, output usesAck);
endinterface

// *** tb/exc_seq_assertions.sv ***
`timescale 1ns/10ps
module exc_seq_assertions
    import exc_seq_pkg::*;
(
    input wire logic        sys_clk, resetn, excReq, seqBusy, // Clock, reset, request
    input wire logic        statusLoad, pcLoad, irqInhibit,   // Load pulses, inhibit level
    input wire logic        busAck, vector_fetch_cycle,       // Bus handshake
    input wire buscmd_t     busCmd,                           // Bus command
    input wire logic [31:0] busAddr, busRdata, handlerPc,     // Addresses and data
    input wire logic [15:0] newStatus,                        // New status word
    input wire logic [11:0] vector_table_base                 // Table base
);
    // --------
    // Sequencer checks
    // --------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_save_first: assert property (excReq && !seqBusy |-> ##2 statusLoad)
        else $error("status save late");
    a_mode_set: assert property (statusLoad |-> newStatus[PSW_S] && !newStatus[PSW_T])
        else $error("mode bits wrong");
    a_write_align: assert property (busCmd == BUS_WRITE |-> busAddr[1:0] == 2'h0)
        else $error("frame not aligned");
    a_ack_window: assert property (vector_fetch_cycle |-> busCmd == BUS_READ && busAddr[31:5] == ACK_BASE[31:5])
        else $error("ack cycle wrong");
    a_bus_hold: assert property (busCmd != BUS_IDLE && !busAck |=> $stable(busCmd) && $stable(busAddr))
        else $error("bus request moved");
    a_idle_quiet: assert property (!seqBusy |-> busCmd == BUS_IDLE)
        else $error("bus used while idle");
    a_fetch_ends: assert property (pcLoad |-> $past(busAck) && !$past(vector_fetch_cycle) ##1 !pcLoad)
        else $error("handler entry wrong");
    a_handler_word: assert property (pcLoad |-> handlerPc == $past(busRdata))
        else $error("handler address wrong");
    a_table_base: assert property (pcLoad |-> ($past(busAddr) & 32'hFFFF_FC00) == {vector_table_base, 20'h0_0000})
        else $error("table fetch outside table");
    a_inhibit_entry: assert property (pcLoad |-> irqInhibit)
        else $error("no inhibit at entry");
endmodule
bind cpu_exception_sequencer exc_seq_assertions chk_u (.sys_clk, .resetn, .excReq, .seqBusy,
    .statusLoad, .pcLoad, .irqInhibit, .busAck, .vector_fetch_cycle, .busCmd, .busAddr,
    .busRdata, .handlerPc, .newStatus, .vector_table_base);

// *** tb/irq_ctrl_model.sv ***
`timescale 1ns/10ps
module irq_ctrl_model
    import exc_seq_pkg::*;
(
    input wire logic        sys_clk, resetn, vector_fetch_cycle, // Clock, reset, ack marker
    input wire buscmd_t     busCmd,   // Bus command
    input wire logic [31:0] busAddr,  // Bus address
    input wire logic [7:0]  irqVec,   // Vector handed back
    input wire logic [3:0]  lat,      // Wait cycles
    output logic            busAck,   // One-cycle completion
    output logic [31:0]     busRdata  // Valid only with busAck
);
    logic [3:0]  waitCnt;
    logic [31:0] val;
    // Memory answers the inverted address, so a wrong fetch shows
    assign val = vector_fetch_cycle ? {24'h00_0000, irqVec} : ~busAddr;
    assign busRdata = busAck ? val : ~val; // Garbage outside the answer
    // Completion after lat waits, prompt or slow
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busAck  <= 1'b0;
            waitCnt <= 4'h0;
        end else begin
            busAck  <= busCmd != BUS_IDLE && !busAck && waitCnt == lat;
            waitCnt <= (busCmd == BUS_IDLE || busAck || waitCnt == lat) ? 4'h0 : waitCnt + 4'h1;
        end
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import exc_seq_pkg::*;
    // --------
    // Stimulus and observation
    // --------
    logic        sys_clk = 0, resetn = 0, excReq = 0, instrDone = 0, busAck, vector_fetch_cycle;
    logic        seqBusy, statusLoad, stackLoad, pcLoad, irqInhibit;
    cause_t      excCause = CAUSE_ACCESS;
    fault_t      faultKind = FAULT_IFETCH;
    buscmd_t     busCmd;
    logic [2:0]  irqLevel = 3'h5;
    logic [3:0]  trapNum = 4'h0, lat = 4'h0, codeTab[4] = '{4'h4, 4'h8, 4'h9, 4'hC};
    logic [7:0]  irqVec = 8'hFF, lastVector;
    logic [7:0]  vt[10] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E};
    logic [11:0] vector_table_base = 12'h123;
    logic [15:0] processor_status_word = 16'h9700, newStatus, ns;
    logic [31:0] faultPc = 32'h0000_1000, nextPc = 32'h0000_1002, stk = 32'h0000_2000;
    logic [31:0] busAddr, busWdata, busRdata, newStackPtr, handlerPc, nsp, ack, wa[2], wd[2];
    int          fail_count = 0, n_compared = 0, nw;
    always #4 sys_clk = ~sys_clk;
    cpu_exception_sequencer dut_u (.sys_clk, .resetn, .excReq, .excCause, .faultKind, .trapNum,
        .irqLevel, .faultPc, .nextPc, .processor_status_word, .supervisor_stack_ptr(stk),
        .vector_table_base, .instrDone, .busCmd, .busAddr, .busWdata, .vector_fetch_cycle,
        .busAck, .busRdata, .seqBusy, .statusLoad, .newStatus, .stackLoad, .newStackPtr, .pcLoad,
        .handlerPc, .irqInhibit, .lastVector);
    irq_ctrl_model ctl_u (.sys_clk, .resetn, .vector_fetch_cycle, .busCmd, .busAddr, .irqVec,
        .lat, .busAck, .busRdata);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // One exception; bus watched at falling edges, where it has settled
    task automatic run(input cause_t c, input logic [1:0] f, input logic [3:0] n,
                       input logic [7:0] v, input logic nxt, input logic [3:0] code);
        logic [31:0] fr;
        logic [15:0] p;
        int          k;
        @(posedge sys_clk) #1;
        excCause = c;
        faultKind = fault_t'(f);
        trapNum = n;
        excReq = 1'b1;
        nw = 0;
        ack = 32'h0;
        p = processor_status_word;
        fr = (stk & ALIGN_MASK) - FRAME_BYTES;
        @(posedge sys_clk) #1 excReq = 1'b0;
        for (k = 0; k < 120 && pcLoad !== 1'b1; k++) begin
            @(negedge sys_clk);
            if (busAck && busCmd == BUS_WRITE && nw < 2) begin
                wa[nw] = busAddr;
                wd[nw] = busWdata;
                nw++;
            end
            if (vector_fetch_cycle) ack = busAddr;
            if (statusLoad) ns = newStatus;
            if (stackLoad) nsp = newStackPtr;
        end
        if (k == 120) begin
            fail_count++;
            print_verdict();
        end
        check({16'h0000, ns}, {17'h0_0000, p[14], 1'b1,
            c == CAUSE_IRQ ? {1'b0, p[11], irqLevel} : p[12:8], p[7:0]});
        check(handlerPc, ~({vector_table_base, 20'h0_0000} + {22'h0, v, 2'b00}));
        check({31'h0, irqInhibit}, 32'h1);
        if (c == CAUSE_RESET) begin
            check(nsp, ~{vector_table_base, 20'h0_0000});
        end else begin
            check(wa[0], fr + WORD_BYTES);
            check(wd[0], nxt ? nextPc : faultPc);
            check(wa[1], fr);
            check(wd[1], {2'b01, stk[1:0], code, v, p});
            check(nsp, fr);
            check(ack, c == CAUSE_IRQ ? ACK_BASE | {27'h0, irqLevel, 2'b00} : 32'h0);
            check({24'h00_0000, lastVector}, {24'h00_0000, v});
        end
        @(posedge sys_clk) #1 instrDone = 1'b1;
        @(posedge sys_clk) #1 instrDone = 1'b0;
        check({31'h0, irqInhibit}, 32'h0);
        stk = stk - 32'h0000_0101;
        lat = lat + 4'h3;
    endtask
    // --------
    // Main sequence
    // --------
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 resetn = 1'b1;
        for (int i = 1; i < 10; i++) begin
            run(cause_t'(i), 2'h0, 4'h0, vt[i], i == 5 || i == 8, 4'h0);
        end
        for (int i = 0; i < 4; i++) begin
            run(CAUSE_ACCESS, i[1:0], 4'h0, 8'h02, 1'b0, codeTab[i]);
        end
        run(CAUSE_TRAP, 2'h0, 4'hF, 8'h2F, 1'b1, 4'h0);
        run(CAUSE_IRQ, 2'h0, 4'h0, 8'hFF, 1'b1, 4'h0);
        run(CAUSE_RESET, 2'h0, 4'h0, 8'h01, 1'b0, 4'h0);
        print_verdict();
    end
endmodule

// *** verilog/cpu_exception_sequencer.sv ***
`timescale 1ns/10ps
module cpu_exception_sequencer (
    input  wire logic                    sys_clk,       // Core clock, 125 MHz
    input  wire logic                    resetn,        // Async reset, active low
    input  wire logic                    excReq,        // Exception request pulse
    input  wire exc_seq_pkg::cause_t     excCause,      // Exception cause
    input  wire exc_seq_pkg::fault_t     faultKind,     // Access error kind
    input  wire logic [3:0]              trapNum,       // Trap instruction number
    input  wire logic [2:0]              irqLevel,      // Level being taken
    input  wire logic [31:0]             faultPc,       // Faulting instruction address
    input  wire logic [31:0]             nextPc,        // Following instruction address
    input  wire logic [15:0]             processor_status_word, // Current status word
    input  wire logic [31:0]             supervisor_stack_ptr,  // Current stack pointer
    input  wire logic [11:0]             vector_table_base,     // Table base, bits 31:20
    input  wire logic                    instrDone,     // Core retired an instruction
    output exc_seq_pkg::buscmd_t         busCmd,        // Core bus command
    output logic [31:0]                  busAddr,       // Core bus address
    output logic [31:0]                  busWdata,      // Core bus write data
    output logic                         vector_fetch_cycle, // Acknowledge read marker
    input  wire logic                    busAck,        // Bus cycle done
    input  wire logic [31:0]             busRdata,      // Bus read data
    output logic                         seqBusy,       // Holds off instruction issue
    output logic                         statusLoad,    // Pulse: load new status word
    output logic [15:0]                  newStatus,     // New status word
    output logic                         stackLoad,     // Pulse: load stack pointer
    output logic [31:0]                  newStackPtr,   // New stack pointer
    output logic                         pcLoad,        // Pulse: start handler fetch
    output logic [31:0]                  handlerPc,     // Handler address
    output logic                         irqInhibit,    // No interrupt sampling
    output logic [7:0]                   lastVector     // Vector of last exception
);
    import exc_seq_pkg::*;

    // ---------------------------------------------------------------
    // Sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SAVE    = 3'b001,
        ST_VECTOR  = 3'b010,
        ST_PUSH_PC = 3'b011,
        ST_PUSH_FV = 3'b100,
        ST_FETCH   = 3'b101,
        ST_RST_SP  = 3'b110,
        ST_RST_PC  = 3'b111
    } state_t;

    state_t       state;
    state_t       next_state;
    cause_t       cause;
    logic [3:0]   trapHeld;
    fault_t       faultHeld;
    logic [2:0]   levelHeld;
    logic [31:0]  savedPc;
    logic [31:0]  nextPcHeld;
    logic [15:0]  savedStatus;
    logic [31:0]  origStack;
    logic [7:0]   vector;
    logic         handlerEntry;
    logic [31:0]  frameBase;
    logic [3:0]   formatField;

    vec_info_if info ();

    // Decoder sees only the held request, never the live inputs
    assign info.cause     = cause;
    assign info.trapNum   = trapHeld;
    assign info.faultKind = faultHeld;

    // ---------------------------------------------------------------
    // Sub-blocks
    // ---------------------------------------------------------------
    exc_vector_decode u_decode (
        .info (info)
    );

    irq_first_guard u_guard (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .handlerEntry (handlerEntry),
        .instrDone    (instrDone),
        .irqInhibit   (irqInhibit)
    );

    // ---------------------------------------------------------------
    // Frame layout
    // ---------------------------------------------------------------
    // Frame lands below the aligned original pointer
    assign frameBase   = (origStack & ALIGN_MASK) - FRAME_BYTES;
    assign formatField = {FMT_HI, origStack[1:0]};

    // ---------------------------------------------------------------
    // Request capture
    // ---------------------------------------------------------------
    // Latched at request so the core may move on its inputs
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cause     <= CAUSE_ACCESS;
            trapHeld  <= 4'h0;
            faultHeld <= FAULT_IFETCH;
            levelHeld <= 3'h0;
            savedPc   <= 32'h0000_0000;
            nextPcHeld <= 32'h0000_0000;
            origStack <= 32'h0000_0000;
        end else if (state == ST_IDLE && excReq) begin
            cause     <= excCause;
            trapHeld  <= trapNum;
            faultHeld <= faultKind;
            levelHeld <= irqLevel;
            origStack <= supervisor_stack_ptr;
            // Both kept; the decoder picks one when the frame is pushed
            savedPc    <= faultPc;
            nextPcHeld <= nextPc;
        end
    end

    // Status copy taken before any change of mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            savedStatus <= 16'h0000;
        end else if (state == ST_IDLE && excReq) begin
            savedStatus <= processor_status_word;
        end
    end

    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Strict step order, one bus cycle at a time
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (excReq) begin
                    next_state = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (cause == CAUSE_RESET) begin
                    next_state = ST_RST_SP;
                end else begin
                    next_state = ST_VECTOR;
                end
            end
            // Acknowledge read only for interrupts; faults pass in one cycle
            ST_VECTOR: begin
                if (!info.usesAck || busAck) begin
                    next_state = ST_PUSH_PC;
                end
            end
            ST_PUSH_PC: begin
                if (busAck) begin
                    next_state = ST_PUSH_FV;
                end
            end
            ST_PUSH_FV: begin
                if (busAck) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (busAck) begin
                    next_state = ST_IDLE;
                end
            end
            ST_RST_SP: begin
                if (busAck) begin
                    next_state = ST_RST_PC;
                end
            end
            ST_RST_PC: begin
                if (busAck) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Vector: internal at save, or from acknowledge answer
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vector <= 8'h00;
        end else if (state == ST_SAVE) begin
            vector <= (cause == CAUSE_RESET) ? 8'h00 : info.vector;
        end else if (state == ST_VECTOR && info.usesAck && busAck) begin
            // Low byte only; answers of 64 and up are peripheral sources
            vector <= busRdata[VEC_W-1:0];
        end
    end

    // Vector of the last completed sequence, visible to software
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lastVector <= 8'h00;
        end else if (handlerEntry) begin
            lastVector <= vector;
        end
    end

    // ---------------------------------------------------------------
    // Status word update
    // ---------------------------------------------------------------
    // Registered from the save step; pulses one cycle later, in the vector step (with the acknowledge read for interrupts) or with the reset stack read
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            statusLoad <= 1'b0;
            newStatus  <= 16'h0000;
        end else begin
            statusLoad <= (state == ST_SAVE);
            if (state == ST_SAVE) begin
                newStatus        <= savedStatus;
                newStatus[PSW_S] <= 1'b1;
                newStatus[PSW_T] <= 1'b0;
                if (cause == CAUSE_IRQ) begin
                    newStatus[PSW_M] <= 1'b0;
                    newStatus[PSW_IPL_HI:PSW_IPL_LO] <= levelHeld;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Core bus drive
    // ---------------------------------------------------------------
    always_comb begin
        busCmd             = BUS_IDLE;
        busAddr            = 32'h0000_0000;
        busWdata           = 32'h0000_0000;
        vector_fetch_cycle = 1'b0;
        case (state)
            // Level rides in the address; the answer carries the vector
            ST_VECTOR: begin
                if (info.usesAck) begin
                    busCmd             = BUS_READ;
                    vector_fetch_cycle = 1'b1;
                    busAddr            = ACK_BASE |
                                         (ADDR_W'(levelHeld) << ACK_LVL_LSB);
                end
            end
            // Fault or next address, as the decoder marks the cause
            ST_PUSH_PC: begin
                busCmd   = BUS_WRITE;
                busAddr  = frameBase + WORD_BYTES;
                busWdata = info.stackNext ? nextPcHeld
                                          : savedPc;
            end
            // Lower longword last, so the pointer drops once the frame is whole
            ST_PUSH_FV: begin
                busCmd   = BUS_WRITE;
                busAddr  = frameBase;
                busWdata = {formatField, info.faultCode,
                            vector, savedStatus};
            end
            ST_FETCH: begin
                busCmd  = BUS_READ;
                busAddr = {vector_table_base, {(BASE_LSB-VEC_W-VEC_SHIFT){1'b0}},
                           vector, {VEC_SHIFT{1'b0}}};
            end
            // Reset reads the first two table words; no frame is pushed
            ST_RST_SP: begin
                busCmd  = BUS_READ;
                busAddr = {vector_table_base, {BASE_LSB{1'b0}}};
            end
            ST_RST_PC: begin
                busCmd  = BUS_READ;
                busAddr = {vector_table_base, {BASE_LSB{1'b0}}} | WORD_BYTES;
            end
            default: busCmd = BUS_IDLE;
        endcase
    end

    // Issue held off for the whole sequence
    assign seqBusy = (state != ST_IDLE);

    // Handler entry marks the end of exception processing
    assign handlerEntry = ((state == ST_FETCH) || (state == ST_RST_PC)) && busAck;

    // ---------------------------------------------------------------
    // Results to the core
    // ---------------------------------------------------------------
    // Pointer moves only after the second write, or the reset stack read, is acknowledged
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stackLoad   <= 1'b0;
            newStackPtr <= 32'h0000_0000;
        end else begin
            stackLoad <= 1'b0;
            if (state == ST_PUSH_FV && busAck) begin
                stackLoad   <= 1'b1;
                newStackPtr <= frameBase;
            end else if (state == ST_RST_SP && busAck) begin
                stackLoad   <= 1'b1;
                newStackPtr <= busRdata;
            end
        end
    end

    // Handler address starts the first opcode fetch
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pcLoad    <= 1'b0;
            handlerPc <= 32'h0000_0000;
        end else begin
            pcLoad <= handlerEntry;
            if (handlerEntry) begin
                handlerPc <= busRdata;
            end
        end
    end

endmodule

// *** verilog/exc_vector_decode.sv ***
`timescale 1ns/10ps
module exc_vector_decode (
    vec_info_if.dec info    // Cause in, vector and frame fields out
);
    import exc_seq_pkg::*;

    // Internal vector, no bus cycle needed, except interrupts, which take the acknowledge read
    always_comb begin
        info.vector    = VEC_ACCESS;
        info.stackNext = 1'b0;
        info.usesAck   = 1'b0;
        case (info.cause)
            CAUSE_ACCESS:  info.vector = VEC_ACCESS;
            CAUSE_ADDRESS: info.vector = VEC_ADDRESS;
            CAUSE_ILLEGAL: info.vector = VEC_ILLEGAL;
            CAUSE_DIVZERO: info.vector = VEC_DIVZERO;
            CAUSE_PRIV:    info.vector = VEC_PRIV;
            CAUSE_LINEA:   info.vector = VEC_LINEA;
            CAUSE_LINEF:   info.vector = VEC_LINEF;
            CAUSE_FORMAT:  info.vector = VEC_FORMAT;
            CAUSE_TRACE: begin
                info.vector    = VEC_TRACE;
                info.stackNext = 1'b1;
            end
            CAUSE_DEBUG: begin
                info.vector    = VEC_DEBUG;
                info.stackNext = 1'b1;
            end
            CAUSE_TRAP: begin
                info.vector    = VEC_TRAP0 | {4'h0, info.trapNum};
                info.stackNext = 1'b1;
            end
            CAUSE_IRQ: begin
                info.usesAck   = 1'b1;
                info.stackNext = 1'b1;
            end
            default:       info.vector = VEC_ACCESS;
        endcase
    end

    // Fault status only for access errors; address errors get none
    always_comb begin
        info.faultCode = FLT_NONE;
        if (info.cause == CAUSE_ACCESS) begin
            case (info.faultKind)
                FAULT_IFETCH:  info.faultCode = FLT_IFETCH;
                FAULT_OPWRITE: info.faultCode = FLT_OPWRITE;
                FAULT_WPROT:   info.faultCode = FLT_WPROT;
                FAULT_OPREAD:  info.faultCode = FLT_OPREAD;
                default:       info.faultCode = FLT_NONE;
            endcase
        end else if (info.cause == CAUSE_ADDRESS) begin
            info.faultCode = FLT_NONE;
        end
    end
endmodule

// *** verilog/irq_first_guard.sv ***
`timescale 1ns/10ps
module irq_first_guard (
    input  wire logic sys_clk,        // Core clock
    input  wire logic resetn,         // Async reset, active low
    input  wire logic handlerEntry,   // Pulse when sequence ends
    input  wire logic instrDone,      // Core retired an instruction
    output logic      irqInhibit      // Holds off interrupt sampling
);
    // Inhibit stays up across the handler's first instruction
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irqInhibit <= 1'b0;
        end else if (handlerEntry) begin
            irqInhibit <= 1'b1;
        end else if (instrDone) begin
            irqInhibit <= 1'b0;
        end
    end
endmodule
